// file: interrupt_priority_mask_stack.sv
// priority controller registers, mask pseudo stack and axi4-lite slave
// assumes irq_accept and src_req come from logic on aclk
// assumes irq_accept is one pulse per interrupt taken by the cpu
// Contract
// (RULE_01) bit 7 enables priority processing
// (RULE_02) disabled: requests pass straight through
// (RULE_03) disabled: pseudo stack never changes
// (RULE_04) enabled: all requests evaluated first
// (RULE_05) bits 6 and 2 read zero
// (RULE_06) bit 5 flags empty stack
// (RULE_07) bit 4 flags full stack
// (RULE_08) push when full drops oldest slot
// (RULE_09) pull bit restores top stacked mask
// (RULE_10) pull shifts stack, zeros fill bottom
// (RULE_11) enabled: level at least mask passes
// (RULE_12) mask write never pushes
// (RULE_13) pull wins over written mask
// (RULE_14) accepted interrupt pushes current mask
// (RULE_15) four 2-bit levels per byte register
// (RULE_16) pull bit is a strobe reading zero
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "prio_defines.svh"
module interrupt_priority_mask_stack
  import prio_pkg::*;
#(
  parameter int NUM_SOURCES = 40
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [15:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [15:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic [NUM_SOURCES-1:0] src_req,
  input wire logic irq_accept,
  output logic [NUM_SOURCES-1:0] cpu_req
);
  // packed width of all level registers, one byte each
  localparam int LVL_W = `LEVEL_REGS * 8;

  // only as many sources as the level registers can hold
  generate
    if (NUM_SOURCES < 1 || NUM_SOURCES > 4 * `LEVEL_REGS) begin : g_chk
      $error("NUM_SOURCES out of range for the level registers");
    end
  endgenerate

  // whole state of the block
  typedef struct packed {
    logic enable; // priority processing on
    level_type mask; // current priority mask
    logic [7:0] stack; // four slots, most recent in [7:6]
    depth_type depth; // valid slots held
    logic [LVL_W-1:0] levels; // level registers, byte per register
    logic aw_held; // write address captured
    logic [15:0] aw_addr; // captured write address
    logic w_held; // write data captured
    logic [7:0] w_byte; // captured low data byte
    logic w_lane0; // captured strobe of the low byte
    logic bvalid; // write response pending
    logic [1:0] bresp; // write response code
    logic rvalid; // read data pending
    logic [31:0] rdata; // read data
    logic [1:0] rresp; // read response code
  } state_type;

  state_type s_q; // registered state
  state_type s_d; // next state

  // map a byte address onto a register, misaligned counts as unmapped
  function automatic reg_sel_type decode(input logic [15:0] a);
    logic [13:0] idx;
    idx = a[15:2];
    if (a[1:0] != 2'h0) begin
      decode = SEL_NONE;
    end else if (idx == `SC_INDEX) begin
      decode = SEL_SC;
    end else if (idx == `STACK_INDEX) begin
      // read only; a write here is answered but changes nothing
      decode = SEL_STACK;
    end else if (idx >= `LEVEL_INDEX &&
                 idx < `LEVEL_INDEX + 14'(`LEVEL_REGS)) begin
      decode = SEL_LEVEL;
    end else begin
      decode = SEL_NONE;
    end
  endfunction

  // which level register an address hits
  function automatic logic [3:0] level_slot(input logic [15:0] a);
    logic [13:0] off;
    off = a[15:2] - `LEVEL_INDEX;
    level_slot = off[3:0];
  endfunction

  reg_sel_type wr_sel; // register hit by the pending write
  reg_sel_type rd_sel; // register hit by the offered read
  logic do_write; // pending write completes this cycle
  logic sc_write; // status/control byte written
  logic pull_now; // pull command takes effect
  logic push_now; // accepted interrupt stacks the mask
  logic empty_flag; // stack holds nothing
  logic full_flag; // all four slots used
  logic [7:0] sc_view; // status/control as read back
  level_type top_slot; // most recent stacked mask
  logic [5:0] low_slots; // the three older slots

  assign wr_sel = decode(s_q.aw_addr);
  assign rd_sel = decode(araddr);
  assign do_write = s_q.aw_held && s_q.w_held && !s_q.bvalid;
  // a write without the low byte lane changes nothing
  assign sc_write = do_write && s_q.w_lane0 && wr_sel == SEL_SC;
  // pull only acts when already enabled; zero in the bit is a no-op
  assign pull_now = sc_write && s_q.w_byte[`SC_PULL_BIT] && // RULE_09
    s_q.enable; // RULE_03 RULE_16
  // a pull in the same cycle takes precedence over a push
  assign push_now = irq_accept && s_q.enable && !pull_now; // RULE_14
  assign empty_flag = (s_q.depth == 3'h0); // RULE_06
  assign full_flag = (s_q.depth == `STACK_DEPTH); // RULE_07
  assign top_slot = s_q.stack[7:6];
  assign low_slots = s_q.stack[5:0];
  // reserved bits and the pull strobe always read zero
  assign sc_view = {s_q.enable, 1'b0, empty_flag, full_flag, // RULE_05
    1'b0, 1'b0, s_q.mask}; // RULE_16

  // bus handshakes, register writes and stack moves
  always_comb begin
    s_d = s_q;
    // address and data may arrive in either order
    if (awvalid && awready) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = awaddr;
    end
    // only the low byte lane matters: every register is one byte
    if (wvalid && wready) begin
      s_d.w_held = 1'b1;
      s_d.w_byte = wdata[7:0];
      s_d.w_lane0 = wstrb[0];
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    // complete the write once both halves are in
    if (do_write) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      if (s_q.w_lane0 && wr_sel == SEL_LEVEL) begin
        s_d.levels[level_slot(s_q.aw_addr)*8 +: 8] = s_q.w_byte; // RULE_15
      end
    end
    // control write: mask goes in directly, stack untouched
    if (sc_write) begin
      s_d.enable = s_q.w_byte[`SC_ENABLE_BIT]; // RULE_01
      s_d.mask = s_q.w_byte[1:0]; // RULE_12
    end
    // depth counts valid slots so the flags do not depend on data:
    // a stacked mask of 0 would otherwise look like a free slot
    // pull overrides any mask value written alongside it
    if (pull_now) begin
      s_d.mask = top_slot; // RULE_13
      s_d.stack = {low_slots, 2'h0}; // RULE_10
      if (!empty_flag) begin
        s_d.depth = s_q.depth - 3'h1; // RULE_06
      end
    end else if (push_now) begin
      // the oldest slot falls off the bottom when full
      s_d.stack = {s_q.mask, s_q.stack[7:2]}; // RULE_08
      if (!full_flag) begin
        s_d.depth = s_q.depth + 3'h1; // RULE_07
      end
    end
    // read: one outstanding answer at a time
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `RESP_OKAY;
      // rebuilt from zero so no byte of an earlier read leaks through
      s_d.rdata = 32'h0000_0000;
      unique case (rd_sel)
        SEL_SC: s_d.rdata[7:0] = sc_view;
        SEL_STACK: s_d.rdata[7:0] = s_q.stack;
        SEL_LEVEL: s_d.rdata[7:0] = s_q.levels[level_slot(araddr)*8 +: 8];
        SEL_NONE: s_d.rresp = `RESP_SLVERR;
      endcase
    end
  end

  // synchronous reset leaves mask zero, stack empty, bypass on
  // status reads 0x20 after reset because the empty flag comes from depth
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ready only while the holding slot is free and no answer waits
  // dropping both with bvalid makes the next write wait until the
  // previous answer has been taken, so one write is in flight at most
  assign awready = !s_q.aw_held && !s_q.bvalid;
  assign wready = !s_q.w_held && !s_q.bvalid;
  assign arready = !s_q.rvalid;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;

  // hand the mask and levels to the per-source gate
  gate_if #(.NUM_SOURCES(NUM_SOURCES), .LVL_W(LVL_W)) gi ();
  assign gi.enable = s_q.enable;
  assign gi.mask = s_q.mask;
  assign gi.levels = s_q.levels;
  assign gi.src_req = src_req;
  assign cpu_req = gi.cpu_req;

  // cpu_req is registered in the gate, one cycle behind src_req
  source_gate #(.NUM_SOURCES(NUM_SOURCES)) source_gate_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .gi(gi)
  );

  // stack and control checks; the bus itself is exercised by the bench
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_enable_from_write: assert property (sc_write |=> // RULE_01
    s_q.enable == $past(s_q.w_byte[`SC_ENABLE_BIT]))
    else $error("enable bit did not follow the write");
  a_bypass_stack_frozen: assert property (!s_q.enable |=> // RULE_03
    $stable(s_q.stack) && $stable(s_q.depth))
    else $error("stack changed while disabled");
  a_reserved_read_zero: assert property ( // RULE_05
    arvalid && arready && rd_sel == SEL_SC |=>
    rdata[6] == 1'b0 && rdata[2] == 1'b0 && rdata[3] == 1'b0)
    else $error("reserved or strobe bit read as one");
  a_push_clears_empty: assert property ( // RULE_06
    push_now && empty_flag |=> !empty_flag ##0 s_q.depth == 3'h1)
    else $error("empty flag stayed after a push");
  a_fourth_push_full: assert property ( // RULE_07
    push_now && s_q.depth == 3'h3 |=> full_flag)
    else $error("full flag missing after fourth push");
  a_full_push_drops: assert property (push_now && full_flag |=> // RULE_08
    s_q.stack == {$past(s_q.mask), $past(s_q.stack[7:2])} && full_flag)
    else $error("overflow did not drop the oldest slot");
  a_pull_restores: assert property (pull_now |=> // RULE_13
    s_q.mask == $past(top_slot))
    else $error("pull did not restore the stacked mask");
  a_pull_shifts: assert property (pull_now |=> // RULE_10
    s_q.stack == {$past(low_slots), 2'h0})
    else $error("pull did not shift the stack");
  a_mask_write_nopush: assert property ( // RULE_12
    sc_write && !pull_now && !push_now |=> $stable(s_q.stack))
    else $error("mask write disturbed the stack");
  a_push_stacks_mask: assert property (push_now |=> // RULE_14
    top_slot == $past(s_q.mask))
    else $error("accepted interrupt did not stack the mask");
  a_pull_pulse_once: assert property (pull_now |=> !pull_now) // RULE_16
    else $error("one pull write acted twice");

  // a mask write without pull goes straight into the mask
  a_mask_write_direct: assert property ( // RULE_12
    sc_write && !pull_now |=> s_q.mask == $past(s_q.w_byte[1:0]))
    else $error("written mask did not land");
  // pull bit while disabled: enable and mask apply, the stack stays
  a_pull_disabled_noop: assert property ( // RULE_03
    sc_write && s_q.w_byte[`SC_PULL_BIT] && !s_q.enable |=>
    s_q.mask == $past(s_q.w_byte[1:0]) && $stable(s_q.stack))
    else $error("pull acted while the controller was disabled");
  // a pull from a non-empty stack frees exactly one slot
  a_pull_drops_depth: assert property ( // RULE_06
    pull_now && !empty_flag |=> s_q.depth == $past(s_q.depth) - 3'h1)
    else $error("pull did not free one slot");
  // a push below full takes exactly one more slot
  a_push_raises_depth: assert property ( // RULE_07
    push_now && !full_flag |=> s_q.depth == $past(s_q.depth) + 3'h1)
    else $error("push did not take one slot");

  c_full_overflow: cover property (push_now && full_flag);
  c_pull_nonempty: cover property (pull_now && !empty_flag);
  c_pull_with_mask: cover property (pull_now && s_q.w_byte[1:0] != top_slot);
  c_bad_address: cover property (arvalid && arready && rd_sel == SEL_NONE);
endmodule
`default_nettype wire

// file: prio_defines.svh
// register indices, field positions, reset values and limits
// assumes it is included by bare name from the design files
`ifndef PRIO_DEFINES_SVH
`define PRIO_DEFINES_SVH

// register indices; byte address on the bus is four times the index
`define SC_INDEX 14'h003E
`define STACK_INDEX 14'h003F
`define LEVEL_INDEX 14'h3050
`define LEVEL_REGS 10
// status/control field positions
`define SC_ENABLE_BIT 7
`define SC_EMPTY_BIT 5
`define SC_FULL_BIT 4
`define SC_PULL_BIT 3
// reset values
`define SC_RESET 8'h20
`define STACK_RESET 8'h00
`define LEVEL_RESET 8'h00
// pseudo stack depth in 2-bit slots
`define STACK_DEPTH 3'h4
// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: prio_pkg.sv
// shared types of the priority mask controller
// assumes prio_defines.svh supplies the numeric constants
package prio_pkg;
  // 2-bit source level or mask
  typedef logic [1:0] level_type;
  // stack occupancy 0..4
  typedef logic [2:0] depth_type;
  // register selected by a bus address
  typedef enum logic [3:0] {
    SEL_NONE = 4'b0001,
    SEL_SC = 4'b0010,
    SEL_STACK = 4'b0100,
    SEL_LEVEL = 4'b1000
  } reg_sel_type;
endpackage

// file: gate_if.sv
// carrier between the register block and the per-source gate
// assumes both ends run on the same aclk
`timescale 1ns/1ps
`default_nettype none
interface gate_if #(parameter int NUM_SOURCES = 40, parameter int LVL_W = 80);
  logic enable; // priority processing on
  logic [1:0] mask; // current priority mask
  logic [LVL_W-1:0] levels; // packed 2-bit level fields
  logic [NUM_SOURCES-1:0] src_req; // raw source requests
  logic [NUM_SOURCES-1:0] cpu_req; // filtered requests
  modport ctrl (output enable, mask, levels, src_req, input cpu_req);
  modport gate (input enable, mask, levels, src_req, output cpu_req);
endinterface
`default_nettype wire

// file: source_gate.sv
// per-source level compare and bypass, registered toward the cpu
// assumes requests come from logic on aclk, so no synchroniser
`timescale 1ns/1ps
`default_nettype none
module source_gate
  import prio_pkg::*;
#(
  parameter int NUM_SOURCES = 40
) (
  input wire logic aclk,
  input wire logic aresetn,
  gate_if.gate gi
);
  // whole state of the gate
  typedef struct packed {
    logic [NUM_SOURCES-1:0] cpu_req;
  } gate_state_type;

  gate_state_type s_q; // registered state
  gate_state_type s_d; // next state
  logic [NUM_SOURCES-1:0] pass; // source may reach the cpu

  // one comparator per source; field k of byte n is source n*4+k
  genvar i;
  generate
    for (i = 0; i < NUM_SOURCES; i++) begin : g_cmp
      // bypass lets everything through, else level at or above mask
      assign pass[i] = !gi.enable || // RULE_02
        (gi.levels[2*i +: 2] >= gi.mask); // RULE_11 RULE_15
    end
  endgenerate

  // every request goes through the evaluation above
  always_comb begin
    s_d = s_q;
    s_d.cpu_req = gi.src_req & pass; // RULE_04
  end

  // register stage keeps the cpu lines glitch free
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign gi.cpu_req = s_q.cpu_req;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_bypass_passes: assert property (!gi.enable |=> // RULE_02
    gi.cpu_req == $past(gi.src_req))
    else $error("bypass did not forward requests unchanged");
  a_mask_blocks_low: assert property ( // RULE_11
    gi.enable && gi.mask == 2'h3 && gi.levels[1:0] != 2'h3 |=> !gi.cpu_req[0])
    else $error("source below mask reached the cpu");
  a_level_lets_high: assert property ( // RULE_04
    gi.enable && gi.src_req[0] && gi.levels[1:0] >= gi.mask |=> gi.cpu_req[0])
    else $error("source at or above mask was held back");
  c_filtered: cover property (gi.enable && |(gi.src_req & ~pass));
endmodule
`default_nettype wire

// file: cpu_side_model.sv
// behavioural stand-in for the interrupt sources and the cpu core
// assumes the bench calls its tasks right after a rising aclk edge
`timescale 1ns/1ps
`default_nettype none
module cpu_side_model #(
  parameter int NUM_SOURCES = 8
) (
  input wire logic aclk,
  output var logic [NUM_SOURCES-1:0] src_req,
  output var logic irq_accept
);
  // sources start quiet so nothing reaches the cpu during reset
  initial begin
    src_req = '0;
    irq_accept = 1'b0;
  end

  // new level pattern on the source lines, held until changed
  task automatic set_req(input logic [NUM_SOURCES-1:0] pattern);
    src_req <= pattern;
    @(posedge aclk);
  endtask

  // the cpu takes one interrupt: a single-cycle acceptance pulse
  task automatic accept();
    irq_accept <= 1'b1;
    @(posedge aclk);
    irq_accept <= 1'b0;
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// file: tb_interrupt_priority_mask_stack.sv
// self-checking bench for the priority mask controller
// assumes the design files and cpu_side_model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "prio_defines.svh"
module tb_interrupt_priority_mask_stack
  import prio_pkg::*;
;
  // byte addresses are four times the register index
  localparam logic [15:0] SC_A = {`SC_INDEX, 2'b00};
  localparam logic [15:0] STK_A = {`STACK_INDEX, 2'b00};
  localparam logic [15:0] LV_A = {`LEVEL_INDEX, 2'b00};
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq_accept;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [7:0] src_req, cpu_req;
  int miscompares = 0;
  int tests_run = 0;

  interrupt_priority_mask_stack #(.NUM_SOURCES(8))
    interrupt_priority_mask_stack_inst (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .src_req(src_req), .irq_accept(irq_accept), .cpu_req(cpu_req));
  cpu_side_model #(.NUM_SOURCES(8)) cpu_side_model_inst (.aclk(aclk),
    .src_req(src_req), .irq_accept(irq_accept));

  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // one comparison, counted; unknowns never match
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // write: address and data offered together, each dropped once taken;
  // bready stays high after the answer so back-to-back writes never
  // toggle it twice in one step; only the watchdog ends a stuck wait
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  // read: data and response taken at the edge rvalid is seen;
  // rready is left high for the same reason as bready above
  task automatic rd(input logic [15:0] a, input logic [7:0] e,
                    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk("rdata", {24'h000000, e}, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  // reset values, unmapped and misaligned accesses
  task automatic t_reset();
    rd(SC_A, 8'h20, `RESP_OKAY);
    rd(STK_A, 8'h00, `RESP_OKAY);
    rd(16'h0100, 8'h00, `RESP_SLVERR);
    wr(16'h00F9, 8'h81, `RESP_SLVERR);
    rd(SC_A, 8'h20, `RESP_OKAY);
  endtask

  // reserved and flag bits ignore writes; stack is read-only
  task automatic t_reserved();
    wr(SC_A, 8'h77, `RESP_OKAY);
    rd(SC_A, 8'h23, `RESP_OKAY);
    wr(STK_A, 8'hFF, `RESP_OKAY);
    rd(STK_A, 8'h00, `RESP_OKAY);
  endtask

  // bypass: mask 3 filters nothing, an acceptance stacks nothing and
  // a pull write is ignored (a pull on the empty stack would load 0)
  task automatic t_bypass();
    cpu_side_model_inst.set_req(8'hA5);
    cpu_side_model_inst.accept();
    @(posedge aclk);
    chk("cpu_req", 32'h000000A5, {24'h000000, cpu_req});
    wr(SC_A, 8'h0B, `RESP_OKAY);
    rd(STK_A, 8'h00, `RESP_OKAY);
    rd(SC_A, 8'h23, `RESP_OKAY);
  endtask

  // every mask value against sources of every level
  task automatic t_filter();
    logic [1:0] lv [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1, 2'h0};
    logic [7:0] e;
    wr(LV_A, 8'hE4, `RESP_OKAY);
    wr(LV_A + 16'h0004, 8'h1B, `RESP_OKAY);
    rd(LV_A + 16'h0004, 8'h1B, `RESP_OKAY);
    cpu_side_model_inst.set_req(8'hFF);
    for (int m = 0; m < 4; m++) begin
      wr(SC_A, 8'h80 | 8'(m), `RESP_OKAY);
      for (int i = 0; i < 8; i++) e[i] = (lv[i] >= 2'(m));
      repeat (2) @(posedge aclk);
      chk("cpu_req", {24'h000000, e}, {24'h000000, cpu_req});
    end
  endtask

  // five pushes (one past full), then four pulls down to empty
  task automatic t_stack();
    logic [7:0] wv [9] = '{8'h81, 8'h82, 8'h83, 8'h80, 8'h81, 8'h8B, 8'h88,
      8'h88, 8'h88};
    logic [7:0] sv [9] = '{8'h40, 8'h90, 8'hE4, 8'h39, 8'h4E, 8'h38, 8'hE0,
      8'h80, 8'h00};
    logic [7:0] cv [9] = '{8'h81, 8'h82, 8'h83, 8'h90, 8'h91, 8'h81, 8'h80,
      8'h83, 8'hA2};
    logic [7:0] prev = 8'h00;
    for (int k = 0; k < 9; k++) begin
      wr(SC_A, wv[k], `RESP_OKAY);
      if (k < 5) begin
        rd(STK_A, prev, `RESP_OKAY);
        cpu_side_model_inst.accept();
      end
      rd(STK_A, sv[k], `RESP_OKAY);
      rd(SC_A, cv[k], `RESP_OKAY);
      prev = sv[k];
    end
  endtask

  // verdict and end of run
  task automatic end_sim();
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // main sequence after a 10-cycle reset
  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 16'h0000;
    araddr = 16'h0000;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_reserved();
    t_bypass();
    t_filter();
    t_stack();
    end_sim();
  end

  // watchdog: the tests need well under 2000 cycles
  initial begin
    repeat (5000) @(posedge aclk);
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
